// ### inc/tcd_params.svh
`ifndef TCD_PARAMS_SVH
`define TCD_PARAMS_SVH
// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define TCD_ADDR_W        8
`define TCD_DATA_W        16
`define TCD_CNT_W         16
`define TCD_FIELD_W       4
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TCD_OFS_IO_CTL    8'h00
`define TCD_OFS_MODE      8'h04
`define TCD_OFS_START     8'h08
`define TCD_OFS_COUNT     8'h0C
`define TCD_OFS_GR_C      8'h10
`define TCD_OFS_GR_D      8'h14
`define TCD_OFS_STATUS    8'h18
`define TCD_OFS_MASK      8'h1C
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TCD_FLD_C_LSB     0
`define TCD_FLD_D_LSB     4
`define TCD_BIT_BUF_A     0
`define TCD_BIT_BUF_B     1
`define TCD_BIT_START     0
`define TCD_BIT_EVT_C     0
`define TCD_BIT_EVT_D     1
`define TCD_FB_TOP        3
`define TCD_FB_LEVEL      2
`define TCD_FB_BOTH       1
`define TCD_FB_FALL       0
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TCD_RST_IO_CTL    8'h00
`define TCD_RST_MODE      2'h0
`define TCD_RST_STATUS    2'h0
`define TCD_RST_MASK      2'h0
`endif

// ### inc/tcd_pkg.sv
`default_nettype none
package tcd_pkg;
  // Function chosen by one 4-bit field
  typedef enum logic [1:0] {
    TCD_OFF,
    TCD_CMP,
    TCD_CAP,
    TCD_BAD
  } tcd_mode_e;
  // Drive of one two-way pin
  typedef struct packed {
    logic level;
    logic oe_n;
  } tcd_pin_s;
  // Decode of one field, used by every channel
  function automatic tcd_mode_e tcd_mode(input logic [3:0] f);
    tcd_mode_e m;
    m = TCD_OFF;
    case (f[3:2])
      2'h0, 2'h1: m = (f[1:0] == 2'h0) ? TCD_OFF : TCD_CMP;
      2'h2:       m = TCD_CAP;
      default:    m = TCD_BAD;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

// ### rtl/tcd_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcd_params.svh"
module tcd_chan
  import tcd_pkg::*;
#(
  parameter int CNT_W = `TCD_CNT_W
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Configuration
  input  wire logic [3:0]       field,
  input  wire logic             buffered,
  input  wire logic             run,
  // Counter and general register
  input  wire logic [CNT_W-1:0] count,
  input  wire logic [CNT_W-1:0] gen_reg,
  // Pin
  input  wire logic             pin_in,
  output var  tcd_pin_s         pin_drv,
  // Events
  output var  logic             cap_hit,
  output var  logic             cmp_hit
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic       pin_prev;   // Pin one cycle ago
  tcd_pin_s   next_drv;   // Next pin drive
  wire        active   = !buffered;
  wire        is_cmp   = (tcd_mode(field) == TCD_CMP) && active;
  wire        is_cap   = (tcd_mode(field) == TCD_CAP) && active;
  wire        rise     = pin_in && !pin_prev;
  wire        fall     = !pin_in && pin_prev;
  wire        one_edge = field[`TCD_FB_FALL] ? fall : rise;
  wire        edge_ok  = field[`TCD_FB_BOTH] ? (rise || fall) : one_edge;

  assign cap_hit = is_cap && edge_ok;
  assign cmp_hit = is_cmp && run && (count == gen_reg);

  // ------------------------------------------------------------
  // Pin action
  // ------------------------------------------------------------
  always_comb
  begin
    next_drv.oe_n  = !is_cmp;
    next_drv.level = pin_drv.level;
    if (!is_cmp)
      next_drv.level = 1'b0;
    else if (!run)
      next_drv.level = field[`TCD_FB_LEVEL];
    else if (cmp_hit)
    begin
      case (field[1:0])
        2'h1:    next_drv.level = 1'b0;
        2'h2:    next_drv.level = 1'b1;
        default: next_drv.level = !pin_drv.level;
      endcase
    end
  end

  // Edge history and pin flops
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_prev <= 1'b0;
      pin_drv  <= '{level: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      pin_prev <= pin_in;
      pin_drv  <= next_drv;
    end
  end
endmodule
`default_nettype wire

// ### rtl/tcd_top.sv
// Overview of operation
// - Upper field drives D, lower field C
// - Top bit clear: compare; 00 off, 11 toggle
// - Second bit picks initial pin level
// - Code 01 drives pin low on match
// - Code 10 drives pin high on match
// - Code 10xx captures from own pin
// - Capture 00 rising, 01 falling edges
// - Second-lowest bit set: capture both edges
// - Lower field same encoding for C
// - Buffer B mode silences upper field
// - Buffer A mode silences lower field
// - Initial level applied only while stopped
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "tcd_params.svh"
module tcd_top
  import tcd_pkg::*;
#(
  parameter int CNT_W = `TCD_CNT_W
)
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Register port
  input  wire logic [`TCD_ADDR_W-1:0]  reg_addr,
  input  wire logic [`TCD_DATA_W-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`TCD_DATA_W-1:0]  reg_rdata,
  // Pin C, index 0
  input  wire logic                    pin_c_in,
  output logic                         pin_c_out,
  output logic                         pin_c_oe_n,
  // Pin D, index 1
  input  wire logic                    pin_d_in,
  output logic                         pin_d_out,
  output logic                         pin_d_oe_n,
  // Interrupt
  output logic                         irq
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0]       io_ctl;      // chan0_cd_io_control
  logic [1:0]       mode;        // Buffer mode bits A and B
  logic             run;         // Counter start bit
  logic [CNT_W-1:0] count;       // Channel counter
  logic [CNT_W-1:0] gen_reg [2]; // General registers C and D
  logic [1:0]       status;      // Sticky event bits
  logic [1:0]       mask;        // Interrupt enables

  // ------------------------------------------------------------
  // Per-channel wires
  // ------------------------------------------------------------
  logic [1:0]       pin_in;      // Pins, C then D
  tcd_pin_s         pin_drv [2]; // Pin drives from channels
  logic [1:0]       cap_hit;     // Capture edges seen
  logic [1:0]       cmp_hit;     // Compare matches seen
  logic [1:0]       evt;         // Any event per channel

  assign pin_in = {pin_d_in, pin_c_in};
  assign evt    = cap_hit | cmp_hit;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire hit_io   = (reg_addr == `TCD_OFS_IO_CTL);
  wire hit_mode = (reg_addr == `TCD_OFS_MODE);
  wire hit_run  = (reg_addr == `TCD_OFS_START);
  wire hit_cnt  = (reg_addr == `TCD_OFS_COUNT);
  wire hit_grc  = (reg_addr == `TCD_OFS_GR_C);
  wire hit_grd  = (reg_addr == `TCD_OFS_GR_D);
  wire hit_sts  = (reg_addr == `TCD_OFS_STATUS);
  wire hit_msk  = (reg_addr == `TCD_OFS_MASK);

  // Write strobes per register
  wire wr_io    = reg_wr && hit_io;
  wire wr_mode  = reg_wr && hit_mode;
  wire wr_run   = reg_wr && hit_run;
  wire wr_cnt   = reg_wr && hit_cnt;
  wire wr_msk   = reg_wr && hit_msk;
  wire [1:0] wr_gr = {reg_wr && hit_grd, reg_wr && hit_grc};

  // Status read clears whatever it returns
  wire rd_sts   = reg_rd && hit_sts;

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  logic [`TCD_DATA_W-1:0] next_rdata;  // Word for next cycle

  // Unmapped addresses and idle cycles read as zero
  always_comb
  begin
    next_rdata = '0;
    if (reg_rd)
    begin
      case (1'b1)
        hit_io:   next_rdata[7:0] = io_ctl;
        hit_mode: next_rdata[1:0] = mode;
        hit_run:  next_rdata[`TCD_BIT_START] = run;
        hit_cnt:  next_rdata[CNT_W-1:0] = count;
        hit_grc:  next_rdata[CNT_W-1:0] = gen_reg[0];
        hit_grd:  next_rdata[CNT_W-1:0] = gen_reg[1];
        hit_sts:  next_rdata[1:0] = status;
        hit_msk:  next_rdata[1:0] = mask;
        default:  next_rdata = '0;
      endcase
    end
  end

  // Read data stands for one cycle only
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else
      reg_rdata <= next_rdata;
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Field and mode bits are plain storage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      io_ctl <= `TCD_RST_IO_CTL;
      mode   <= `TCD_RST_MODE;
      run    <= 1'b0;
      mask   <= `TCD_RST_MASK;
    end
    else
    begin
      if (wr_io)
        io_ctl <= reg_wdata[7:0];
      if (wr_mode)
        mode <= reg_wdata[1:0];
      if (wr_run)
        run <= reg_wdata[`TCD_BIT_START];
      if (wr_msk)
        mask <= reg_wdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic [CNT_W-1:0] next_count;  // Counter next value

  // Software write wins over counting
  always_comb
  begin
    next_count = count;
    if (wr_cnt)
      next_count = reg_wdata[CNT_W-1:0];
    else if (run)
      next_count = count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      count <= '0;
    else
      count <= next_count;
  end

  // ------------------------------------------------------------
  // Channels C and D
  // ------------------------------------------------------------
  // Index 0 is C with buffer A, index 1 is D with buffer B
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    logic [CNT_W-1:0] next_gr;   // General register next value
    // Upper field to D, lower to C
    wire  [3:0] field = io_ctl[4*i+3:4*i];
    wire        buffered = mode[i];

    tcd_chan #(
      .CNT_W    (CNT_W)
    ) u_chan (
      .clk      (clk),
      .srst     (srst),
      .field    (field),
      .buffered (buffered),
      .run      (run),
      .count    (count),
      .gen_reg  (gen_reg[i]),
      .pin_in   (pin_in[i]),
      .pin_drv  (pin_drv[i]),
      .cap_hit  (cap_hit[i]),
      .cmp_hit  (cmp_hit[i])
    );

    // Capture copies counter
    // A capture in the cycle of a software write keeps the
    // captured value, so no edge is lost to a busy driver.
    always_comb
    begin
      next_gr = gen_reg[i];
      if (cap_hit[i])
        next_gr = count;
      else if (wr_gr[i])
        next_gr = reg_wdata[CNT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
      if (srst)
        gen_reg[i] <= '0;
      else
        gen_reg[i] <= next_gr;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  logic [1:0] next_status;  // Sticky bits next value
  logic       next_irq;     // Interrupt next level

  // An event in the clearing read cycle stays set
  always_comb
  begin
    next_status = status;
    if (rd_sts)
      next_status = '0;
    next_status = next_status | evt;
    next_irq    = |(next_status & mask);
  end

  // Interrupt registered on the same edge as status, no glitch
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status <= `TCD_RST_STATUS;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq    <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  // These come straight from the channel flops
  assign pin_c_out  = pin_drv[0].level;
  assign pin_c_oe_n = pin_drv[0].oe_n;
  assign pin_d_out  = pin_drv[1].level;
  assign pin_d_oe_n = pin_drv[1].oe_n;

endmodule
`default_nettype wire

// ### tb/tcd_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcd_params.svh"
module tcd_top_assertions
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and interrupt
  input wire logic        pin_c_in,
  input wire logic        pin_c_out,
  input wire logic        pin_c_oe_n,
  input wire logic        pin_d_in,
  input wire logic        pin_d_out,
  input wire logic        pin_d_oe_n,
  input wire logic        irq
);
  // ----------------
  // Software shadow
  // ----------------
  logic [7:0] io;    // Field copy
  logic [1:0] mode;  // Buffer bits
  logic [1:0] mask;  // Mask copy
  logic       run;   // Start bit
  // Pin driven: compare with an action, not buffered
  wire c_drv = !mode[0] && !io[3] && io[1:0] != 2'h0;
  wire d_drv = !mode[1] && !io[7] && io[5:4] != 2'h0;
  // Follows writes only, so a wrong decode in the design shows up
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      io   <= 8'h00;
      mode <= 2'h0;
      mask <= 2'h0;
      run  <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TCD_OFS_IO_CTL) io <= reg_wdata[7:0];
      if (reg_addr == `TCD_OFS_MODE) mode <= reg_wdata[1:0];
      if (reg_addr == `TCD_OFS_MASK) mask <= reg_wdata[1:0];
      if (reg_addr == `TCD_OFS_START) run <= reg_wdata[0];
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  a_rd_ctl: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == {8'h00, $past(io)})
    else $error("field register read back wrong");
  a_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 8'h1C
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_oe_pin_c: assert property (
    $stable(c_drv) |-> pin_c_oe_n == !c_drv) else $error("pin c enable wrong");
  a_oe_pin_d: assert property (
    $stable(d_drv) |-> pin_d_oe_n == !d_drv) else $error("pin d enable wrong");
  a_init_level: assert property (
    !run && !$past(run) && c_drv && $stable(c_drv) && $stable(io) |-> pin_c_out == io[2])
    else $error("initial level wrong while stopped");
  a_match_action: assert property (
    run && $past(run) && c_drv && $stable(c_drv) && $stable(io) && $changed(pin_c_out)
    |-> io[1:0] == 2'h3 || pin_c_out == io[1]) else $error("match action wrong");
  a_irq_masked: assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !irq)
    else $error("interrupt while fully masked");
  // Main scenarios reached
  c_match: cover property (run && !pin_c_oe_n && $changed(pin_c_out));
  c_irq: cover property ($rose(irq));
  c_read: cover property ($past(reg_rd) && reg_rdata != 16'h0000);
endmodule
bind tcd_top tcd_top_assertions tcd_top_assertions_inst (.clk, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_c_in, .pin_c_out, .pin_c_oe_n,
  .pin_d_in, .pin_d_out, .pin_d_oe_n, .irq);
`default_nettype wire

// ### tb/tcd_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcd_pin_model
(
  // Level the far side wants
  input  wire logic ext_lvl,
  // Device side of the pin
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_in
);
  // ----------------
  // Wire level
  // ----------------
  // own pin as source
  // The device wins while driving, so no contention is modelled
  assign pin_in = pin_oe_n ? ext_lvl : pin_out;
endmodule
`default_nettype wire

// ### tb/timer_ch0_cd_io_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcd_params.svh"
module timer_ch0_cd_io_control_test;
  // ----------------
  // Signals
  // ----------------
  logic        clk;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  wire  [1:0]  pin_in;    // Index 0 is C, 1 is D
  wire  [1:0]  pin_out;   // One driver per bit, so nets
  wire  [1:0]  pin_oe_n;
  logic [1:0]  ext_lvl;   // Far side levels
  logic        irq;
  logic        exp_lvl;
  logic        hit;
  int          n_errors;
  int          checks;
  int          code;
  int          r;
  int          exp_gen;   // Model of the general register
  tcd_top tcd_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_c_in(pin_in[0]), .pin_c_out(pin_out[0]), .pin_c_oe_n(pin_oe_n[0]),
    .pin_d_in(pin_in[1]), .pin_d_out(pin_out[1]), .pin_d_oe_n(pin_oe_n[1]), .irq(irq));
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    tcd_pin_model tcd_pin_model_inst (.ext_lvl(ext_lvl[i]), .pin_out(pin_out[i]),
      .pin_oe_n(pin_oe_n[i]), .pin_in(pin_in[i]));
  end
  // Free-running clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask
  // Hang guard, far above the expected run length
  initial
  begin
    repeat (8000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, ext_lvl} = {3'h4, 8'h00, 16'h0000, 2'h0};
    n_errors = 0;
    checks = 0;
    r = $urandom(32'h4621);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset enable", 16'(pin_oe_n), 16'h0003);
    chk("reset level", 16'(pin_out), 16'h0000);
    chk("reset irq", 16'(irq), 16'h0000);
    for (int a = 0; a <= 32; a += 4)
      rd_chk(a[7:0], 16'h0000, "reset value");
    wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, 16'h0000, "unmapped");
    // Prohibited 11xx codes are never written
    r = $urandom & 32'hBB;
    wr(`TCD_OFS_IO_CTL, r[15:0]);
    rd_chk(`TCD_OFS_IO_CTL, r[15:0], "field register");
    // Code x100 keeps both pins released, level bit notwithstanding
    wr(`TCD_OFS_IO_CTL, 16'h0044);
    repeat (2) @(posedge clk);
    #1;
    chk("disabled enable", 16'(pin_oe_n), 16'h0003);
    chk("disabled level", 16'(pin_out), 16'h0000);
    // Every compare code on both channels, last pass buffered
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 7; k++)
      begin
        code = (k == 6) ? 3 : k + 1 + int'(k > 2);
        wr(`TCD_OFS_MODE, 16'(k == 6) << ch);
        wr(`TCD_OFS_MASK, ch ? 16'h1 : 16'h3);
        wr(`TCD_OFS_GR_C + 8'(4 * ch), 16'h0004);
        wr(`TCD_OFS_COUNT, 16'h0000);
        wr(`TCD_OFS_IO_CTL, 16'(code << 4 * ch));
        repeat (2) @(posedge clk);
        #1;
        chk("enable", 16'(pin_oe_n[ch]), 16'(k == 6));
        chk("initial level", 16'(pin_out[ch]), 16'(k < 6 && code[2]));
        wr(`TCD_OFS_START, 16'h0001);
        // Single match at count 4; look before the stop restores the start level
        repeat (7) @(posedge clk);
        #1;
        exp_lvl = (k < 6) && (code[1:0] == 2'h3 ? !code[2] : code[1]);
        chk("match level", 16'(pin_out[ch]), 16'(exp_lvl));
        wr(`TCD_OFS_START, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk("stopped level", 16'(pin_out[ch]), 16'(k < 6 && code[2]));
        chk("irq", 16'(irq), 16'(k < 6 && ch == 0));
        rd_chk(`TCD_OFS_STATUS, k < 6 ? 16'(1 << ch) : 16'h0000, "status");
        @(posedge clk);
        #1;
        chk("irq cleared", 16'(irq), 16'h0000);
      end
    wr(`TCD_OFS_MODE, 16'h0000);
    wr(`TCD_OFS_MASK, 16'h0000);
    // Capture codes: rising, falling, both; counter stopped so the value is known
    for (int ch = 0; ch < 2; ch++)
      for (code = 8; code < 12; code++)
      begin
        wr(`TCD_OFS_IO_CTL, 16'h0000);
        ext_lvl[ch] <= 1'b0;
        wr(`TCD_OFS_GR_C + 8'(4 * ch), 16'h0000);
        exp_gen = 0;
        wr(`TCD_OFS_IO_CTL, 16'(code << 4 * ch));
        for (int e = 0; e < 2; e++)
        begin
          r = $urandom;
          wr(`TCD_OFS_COUNT, r[15:0]);
          ext_lvl[ch] <= (e == 0);
          repeat (3) @(posedge clk);
          hit = code[1] || (code[0] == (e == 1));
          if (hit)
            exp_gen = r;
          rd_chk(`TCD_OFS_GR_C + 8'(4 * ch), exp_gen[15:0], "capture");
          rd_chk(`TCD_OFS_STATUS, 16'(hit) << ch, "capture status");
        end
      end
    give_verdict();
  end
endmodule
`default_nettype wire
